// *** logic/pmc_pkg.sv ***
// constants shared by the power mode and oscillator calibration block
package pmc_pkg;
	// memory-mapped register addresses
	localparam logic [31:0] PMC_ADDR_PREKEY  = 32'hffff0404;
	localparam logic [31:0] PMC_ADDR_POWCTL  = 32'hffff0408;
	localparam logic [31:0] PMC_ADDR_POSTKEY = 32'hffff040c;
	localparam logic [31:0] PMC_ADDR_TRIM    = 32'hffff042c;
	localparam logic [31:0] PMC_ADDR_CALCTL  = 32'hffff0440;
	localparam logic [31:0] PMC_ADDR_CALSTA  = 32'hffff0444;
	localparam logic [31:0] PMC_ADDR_REFCNT  = 32'hffff0448;
	localparam logic [31:0] PMC_ADDR_LPCNT   = 32'hffff044c;
	// key values around a power_control write
	localparam logic [31:0] PMC_PREKEY_VAL   = 32'h00000001;
	localparam logic [31:0] PMC_POSTKEY_VAL  = 32'h000000f4;
	// power_control fields
	localparam int          PMC_PC_CD_LSB    = 0;
	localparam int          PMC_PC_CD_W      = 3;
	localparam int          PMC_PC_CORE      = 3;
	localparam int          PMC_PC_PERIPH    = 4;
	localparam int          PMC_PC_PLL       = 5;
	localparam int          PMC_PC_XTAL      = 6;
	localparam int          PMC_PC_PREC      = 7;
	localparam logic [7:0]  PMC_PC_RESET     = 8'h79;
	// peripheral gate vector layout
	localparam int          PMC_GATE_SRAM    = 0;
	localparam int          PMC_GATE_FLASH   = 1;
	localparam int          PMC_GATE_GPIO    = 2;
	localparam int          PMC_GATE_SPI     = 3;
	localparam int          PMC_GATE_UART    = 4;
	localparam int          PMC_GATE_W       = 5;
	// lp_osc_trim
	localparam int          PMC_TRIM_W       = 4;
	localparam logic [3:0]  PMC_TRIM_RESET   = 4'h8;
	// calibration_control fields
	localparam int          PMC_CC_EN        = 0;
	localparam int          PMC_CC_CLR_REF   = 1;
	localparam int          PMC_CC_CLR_LP    = 2;
	localparam int          PMC_CC_RST       = 3;
	localparam int          PMC_CC_SRC       = 4;
	// calibration_status fields and state codes
	localparam int          PMC_CS_BUSY      = 0;
	localparam int          PMC_CS_EN        = 1;
	localparam int          PMC_CS_ST_LSB    = 2;
	localparam logic [1:0]  PMC_ST_IDLE      = 2'h0;
	localparam logic [1:0]  PMC_ST_ARM       = 2'h1;
	localparam logic [1:0]  PMC_ST_COUNT     = 2'h2;
	localparam logic [1:0]  PMC_ST_DONE      = 2'h3;
	// calibration counters
	localparam int          PMC_REF_W        = 9;
	localparam int          PMC_LP_W         = 10;
	localparam logic [8:0]  PMC_REF_TERM     = 9'h1ff;
	localparam logic [2:0]  PMC_LP_DIV_LOG2  = 3'h2;

	typedef enum logic [1:0] {PMC_KEY_IDLE, PMC_KEY_ARMED, PMC_KEY_HELD} pmc_key_e;
	typedef enum logic [1:0] {PMC_CAL_IDLE, PMC_CAL_ARM, PMC_CAL_COUNT, PMC_CAL_DONE} pmc_cal_e;
endpackage : pmc_pkg

// *** logic/pmc_pulse_div.sv ***
// divides a tick enable by a power of two chosen at run time
`timescale 1ns/1ps
`default_nettype none
module pmc_pulse_div #(
	parameter int CW = 7
) (
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	input  wire logic            tick_i,
	input  wire logic [2:0]      log2_i,
	output logic                 tick_o
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic [CW-1:0] mask;

	always_comb begin
		mask    = CW'((32'h1 << log2_i) - 32'h1);
		nxt_cnt = tick_i ? cnt_ff + CW'(1) : cnt_ff;
		// one pulse every 2**log2 input ticks
		tick_o  = tick_i && ((cnt_ff | ~mask) == {CW{1'b1}});
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : pmc_pulse_div
`default_nettype wire

// *** logic/pmc_cal_counter.sv ***
// saturating up counter with synchronous clear for oscillator calibration
`timescale 1ns/1ps
`default_nettype none
module pmc_cal_counter #(
	parameter int W = 9
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         clr_i,
	input  wire logic         inc_i,
	output logic [W-1:0]      cnt_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (clr_i) begin
			nxt_cnt = '0;
		end else if (inc_i && (cnt_ff != {W{1'b1}})) begin
			nxt_cnt = cnt_ff + W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign cnt_o = cnt_ff;
endmodule : pmc_cal_counter
`default_nettype wire

// *** logic/pmc_top.sv ***
// power mode control with keyed register and low power oscillator calibration
`timescale 1ns/1ps
`default_nettype none
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic                          CLK_SYS_I,
	input  wire logic                          ARST_N_I,
	input  wire logic [31:0]                   MMR_ADDR_I,
	input  wire logic                          MMR_WR_I,
	input  wire logic [31:0]                   MMR_WDATA_I,
	input  wire logic                          MMR_RD_I,
	output logic      [31:0]                   MMR_RDATA_O,
	input  wire logic                          WAKEUP_I,
	input  wire logic                          PLL_TICK_I,
	input  wire logic                          PREC_OSC_TICK_I,
	input  wire logic                          XTAL_TICK_I,
	input  wire logic                          LP_OSC_TICK_I,
	input  wire logic                          HV_PREC_OSC_EN_I,
	input  wire logic                          WAKE_TMR_LP_SRC_I,
	input  wire logic                          TIMER_SRC_PLL_I,
	output logic                               CORE_CLK_EN_O,
	output logic                               CORE_PWR_EN_O,
	output logic      [pmc_pkg::PMC_GATE_W-1:0] PERIPH_GATE_EN_O,
	output logic                               PLL_PWR_EN_O,
	output logic                               XTAL_PWR_EN_O,
	output logic                               PREC_IN_EN_O,
	output logic                               LIN_WAKE_DET_EN_O,
	output logic                               WAKE_TMR_RUN_O,
	output logic                               TIMER_RUN_O,
	output logic      [pmc_pkg::PMC_TRIM_W-1:0] LP_OSC_TRIM_O
);
	import pmc_pkg::*;

	// ---------------- keyed power control ----------------
	pmc_key_e              key_ff;
	pmc_key_e              nxt_key;
	logic [7:0]            pend_ff;
	logic [7:0]            nxt_pend;
	logic [7:0]            pc_ff;
	logic [7:0]            nxt_pc;
	logic [7:0]            eff;
	logic                  core_on;
	logic                  periph_on;
	logic                  pll_on;

	always_comb begin
		nxt_key  = PMC_KEY_IDLE;
		nxt_pend = pend_ff;
		nxt_pc   = pc_ff;
		eff      = pend_ff;
		// interlocks: core holds peripherals up, either holds the PLL up
		eff[PMC_PC_PERIPH] = pend_ff[PMC_PC_PERIPH] | pend_ff[PMC_PC_CORE];
		eff[PMC_PC_PLL]    = pend_ff[PMC_PC_PLL] | eff[PMC_PC_PERIPH];
		if (!MMR_WR_I) begin
			nxt_key = key_ff;
		end else if (MMR_ADDR_I == PMC_ADDR_PREKEY && MMR_WDATA_I == PMC_PREKEY_VAL) begin
			nxt_key = PMC_KEY_ARMED;
		end else if (key_ff == PMC_KEY_ARMED && MMR_ADDR_I == PMC_ADDR_POWCTL) begin
			nxt_key  = PMC_KEY_HELD;
			nxt_pend = MMR_WDATA_I[7:0];
		end else if (key_ff == PMC_KEY_HELD && MMR_ADDR_I == PMC_ADDR_POSTKEY
				&& MMR_WDATA_I == PMC_POSTKEY_VAL) begin
			nxt_pc = eff;
		end
		// a wake-up event wins over a committing write in the same cycle
		if (WAKEUP_I) begin
			nxt_pc[PMC_PC_CORE]   = 1'b1;
			nxt_pc[PMC_PC_PERIPH] = 1'b1;
			nxt_pc[PMC_PC_PLL]    = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			key_ff  <= PMC_KEY_IDLE;
			pend_ff <= '0;
			pc_ff   <= PMC_PC_RESET;
		end else begin
			key_ff  <= nxt_key;
			pend_ff <= nxt_pend;
			pc_ff   <= nxt_pc;
		end
	end

	assign core_on   = pc_ff[PMC_PC_CORE];
	assign periph_on = pc_ff[PMC_PC_PERIPH];
	assign pll_on    = pc_ff[PMC_PC_PLL];

	logic pll_tick_gated;
	logic core_tick;
	assign pll_tick_gated = PLL_TICK_I && pll_on;

	pmc_pulse_div #(
		.CW      (7)
	) u_core_div (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (ARST_N_I),
		.tick_i  (pll_tick_gated),
		.log2_i  (pc_ff[PMC_PC_CD_LSB +: PMC_PC_CD_W]),
		.tick_o  (core_tick)
	);

	assign CORE_CLK_EN_O     = core_tick && core_on;
	assign CORE_PWR_EN_O     = core_on;
	assign PERIPH_GATE_EN_O  = {PMC_GATE_W{periph_on}};
	assign PLL_PWR_EN_O      = pll_on;
	assign XTAL_PWR_EN_O     = pc_ff[PMC_PC_XTAL];
	assign PREC_IN_EN_O      = pc_ff[PMC_PC_PREC] && HV_PREC_OSC_EN_I;
	assign LIN_WAKE_DET_EN_O = 1'b1;
	assign WAKE_TMR_RUN_O    = periph_on || WAKE_TMR_LP_SRC_I;
	// a timer on the PLL clock freezes with it, others are left alone
	assign TIMER_RUN_O       = pll_on || !TIMER_SRC_PLL_I;

	// ---------------- trim and calibration control ----------------
	logic [PMC_TRIM_W-1:0] trim_ff;
	logic [PMC_TRIM_W-1:0] nxt_trim;
	logic                  src_ff;
	logic                  nxt_src;
	logic                  en_ff;
	logic                  nxt_en;
	pmc_cal_e              cal_ff;
	pmc_cal_e              nxt_cal;
	logic                  ctl_wr;
	logic                  start;
	logic                  abort;
	logic                  clr_ref;
	logic                  clr_lp;
	logic                  counting;
	logic [1:0]            st_code;
	logic [PMC_REF_W-1:0]  ref_cnt;
	logic [PMC_LP_W-1:0]   lp_cnt;

	assign ctl_wr = MMR_WR_I && MMR_ADDR_I == PMC_ADDR_CALCTL;

	always_comb begin
		nxt_trim = trim_ff;
		nxt_src  = src_ff;
		nxt_en   = en_ff;
		nxt_cal  = cal_ff;
		clr_ref  = 1'b0;
		clr_lp   = 1'b0;
		if (MMR_WR_I && MMR_ADDR_I == PMC_ADDR_TRIM) begin
			// higher trim slows the oscillator; upper nibble is not writable
			nxt_trim = MMR_WDATA_I[PMC_TRIM_W-1:0];
		end
		if (ctl_wr) begin
			nxt_src = MMR_WDATA_I[PMC_CC_SRC];
			nxt_en  = MMR_WDATA_I[PMC_CC_EN] && !MMR_WDATA_I[PMC_CC_RST];
			clr_ref = MMR_WDATA_I[PMC_CC_CLR_REF] || MMR_WDATA_I[PMC_CC_RST];
			clr_lp  = MMR_WDATA_I[PMC_CC_CLR_LP] || MMR_WDATA_I[PMC_CC_RST];
		end
		start = !en_ff && nxt_en;
		abort = en_ff && !nxt_en;
		unique case (cal_ff)
			PMC_CAL_IDLE: begin
				if (start) begin
					nxt_cal = PMC_CAL_ARM;
				end
			end
			PMC_CAL_ARM: begin
				clr_ref = 1'b1;
				clr_lp  = 1'b1;
				nxt_cal = abort ? PMC_CAL_IDLE : PMC_CAL_COUNT;
			end
			PMC_CAL_COUNT: begin
				if (abort) begin
					nxt_cal = PMC_CAL_IDLE;
				end else if (ref_cnt == PMC_REF_TERM) begin
					nxt_cal = PMC_CAL_DONE;
				end
			end
			PMC_CAL_DONE: begin
				nxt_cal = PMC_CAL_IDLE;
				if (!ctl_wr) begin
					nxt_en = 1'b0;
				end
			end
		endcase
		// 511 reference ticks give about 4 ms at 131 kHz or 16 ms at 32 kHz
		counting = cal_ff == PMC_CAL_COUNT && ref_cnt != PMC_REF_TERM;
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			trim_ff <= PMC_TRIM_RESET;
			src_ff  <= 1'b0;
			en_ff   <= 1'b0;
			cal_ff  <= PMC_CAL_IDLE;
		end else begin
			trim_ff <= nxt_trim;
			src_ff  <= nxt_src;
			en_ff   <= nxt_en;
			cal_ff  <= nxt_cal;
		end
	end

	assign LP_OSC_TRIM_O = trim_ff;

	logic ref_tick;
	logic lp_div_tick;
	logic lp_tick;
	assign ref_tick = src_ff ? (XTAL_TICK_I && pc_ff[PMC_PC_XTAL])
	                         : (PREC_OSC_TICK_I && PREC_IN_EN_O);

	pmc_pulse_div #(
		.CW      (3)
	) u_lp_div (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (ARST_N_I),
		.tick_i  (LP_OSC_TICK_I),
		.log2_i  (PMC_LP_DIV_LOG2),
		.tick_o  (lp_div_tick)
	);

	// the crystal reference runs at a quarter rate, so the divided path follows it
	assign lp_tick = src_ff ? lp_div_tick : LP_OSC_TICK_I;

	pmc_cal_counter #(
		.W       (PMC_REF_W)
	) u_ref_cnt (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (ARST_N_I),
		.clr_i   (clr_ref),
		.inc_i   (counting && ref_tick),
		.cnt_o   (ref_cnt)
	);

	pmc_cal_counter #(
		.W       (PMC_LP_W)
	) u_lp_cnt (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (ARST_N_I),
		.clr_i   (clr_lp),
		.inc_i   (counting && lp_tick),
		.cnt_o   (lp_cnt)
	);

	// ---------------- register read ----------------
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	always_comb begin
		unique case (cal_ff)
			PMC_CAL_IDLE:  st_code = PMC_ST_IDLE;
			PMC_CAL_ARM:   st_code = PMC_ST_ARM;
			PMC_CAL_COUNT: st_code = PMC_ST_COUNT;
			PMC_CAL_DONE:  st_code = PMC_ST_DONE;
		endcase
		nxt_rdata = rdata_ff;
		if (MMR_RD_I) begin
			nxt_rdata = '0;
			unique case (MMR_ADDR_I)
				PMC_ADDR_POWCTL: nxt_rdata[7:0] = pc_ff;
				PMC_ADDR_TRIM:   nxt_rdata[PMC_TRIM_W-1:0] = trim_ff;
				PMC_ADDR_CALCTL: begin
					nxt_rdata[PMC_CC_SRC] = src_ff;
					nxt_rdata[PMC_CC_EN]  = en_ff;
				end
				PMC_ADDR_CALSTA: begin
					nxt_rdata[PMC_CS_ST_LSB +: 2] = st_code;
					nxt_rdata[PMC_CS_EN]          = en_ff;
					nxt_rdata[PMC_CS_BUSY]        = cal_ff == PMC_CAL_ARM
					                                || cal_ff == PMC_CAL_COUNT;
				end
				PMC_ADDR_REFCNT: nxt_rdata[PMC_REF_W-1:0] = ref_cnt;
				PMC_ADDR_LPCNT:  nxt_rdata[PMC_LP_W-1:0]  = lp_cnt;
				default:         nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign MMR_RDATA_O = rdata_ff;

	// ---------------- assertions ----------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!ARST_N_I);

	sequence s_key_commit;
		key_ff == PMC_KEY_HELD && MMR_WR_I && MMR_ADDR_I == PMC_ADDR_POSTKEY
			&& MMR_WDATA_I == PMC_POSTKEY_VAL;
	endsequence

	sequence s_run_start;
		cal_ff == PMC_CAL_ARM ##1 cal_ff == PMC_CAL_COUNT;
	endsequence

	a_cd_full_rate: assert property (
		(PLL_TICK_I && pll_on && core_on && pc_ff[2:0] == 3'h0) |-> CORE_CLK_EN_O)
		else $error("core clock enable missing at divide by one");
	a_cd_needs_tick: assert property (
		CORE_CLK_EN_O |-> PLL_TICK_I && pc_ff[PMC_PC_PLL])
		else $error("core clock enable without a PLL tick");
	a_pll_interlock: assert property (
		!PLL_PWR_EN_O |-> !CORE_PWR_EN_O && !PERIPH_GATE_EN_O[PMC_GATE_SRAM])
		else $error("PLL down while core or peripherals up");
	a_wake_powers_up: assert property (
		WAKEUP_I |=> CORE_PWR_EN_O && PERIPH_GATE_EN_O[PMC_GATE_UART] && PLL_PWR_EN_O)
		else $error("wake-up did not restore power bits");
	a_periph_interlock: assert property (
		!periph_on |-> !core_on)
		else $error("peripherals down while core up");
	a_prec_enable: assert property (
		PREC_IN_EN_O == (pc_ff[PMC_PC_PREC] && HV_PREC_OSC_EN_I))
		else $error("precision input enable wrong");
	a_key_guard: assert property (
		(pc_ff != $past(pc_ff) && !$past(WAKEUP_I)) |-> $past(key_ff == PMC_KEY_HELD))
		else $error("power control changed without keys");
	a_key_commit: assert property (
		(s_key_commit and !WAKEUP_I) |=> pc_ff == $past(eff))
		else $error("keyed write not committed");
	a_ref_stop: assert property (
		(cal_ff == PMC_CAL_COUNT && ref_cnt == PMC_REF_TERM && !abort)
		|=> cal_ff == PMC_CAL_DONE && $stable(ref_cnt) && $stable(lp_cnt))
		else $error("counters did not stop at terminal count");
	a_run_start: assert property (
		(cal_ff == PMC_CAL_IDLE && start)
		|=> s_run_start or (cal_ff == PMC_CAL_ARM ##1 cal_ff == PMC_CAL_IDLE))
		else $error("calibration did not start");
	a_done_idle: assert property (
		cal_ff == PMC_CAL_DONE |=> cal_ff == PMC_CAL_IDLE && st_code == PMC_ST_IDLE)
		else $error("finished state did not return to idle");
	a_abort_run: assert property (
		(cal_ff == PMC_CAL_COUNT && abort) |=> cal_ff == PMC_CAL_IDLE && !en_ff)
		else $error("calibration not aborted");
endmodule : pmc_top
`default_nettype wire

// *** verification/pmc_tb.sv ***
// self-checking testbench for the power mode and oscillator calibration block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pmc_pkg::*;
	logic                  clk_sys   = 1'b0;
	logic                  arst_n    = 1'b0;
	logic [31:0]           addr      = '0;
	logic                  wr        = 1'b0;
	logic [31:0]           wdata     = '0;
	logic                  rd        = 1'b0;
	logic                  wake      = 1'b0;
	logic                  pll_tick  = 1'b0;
	logic                  prec_tick = 1'b0;
	logic                  xtal_tick = 1'b0;
	logic                  lp_tick   = 1'b0;
	logic                  hv_en     = 1'b0;
	logic                  wt_lp     = 1'b0;
	logic                  tmr_pll   = 1'b1;
	logic [31:0]           rdata;
	logic                  core_clk, core_pwr, pll_pwr, xtal_pwr, prec_en, lin_en, wt_run, tmr_run;
	logic [PMC_GATE_W-1:0] gate;
	logic [PMC_TRIM_W-1:0] trim;
	int                    mismatches  = 0;
	int                    check_count = 0;

	always #4 clk_sys = ~clk_sys;

	pmc_top i_dut (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .MMR_ADDR_I(addr), .MMR_WR_I(wr),
		.MMR_WDATA_I(wdata), .MMR_RD_I(rd), .MMR_RDATA_O(rdata), .WAKEUP_I(wake),
		.PLL_TICK_I(pll_tick), .PREC_OSC_TICK_I(prec_tick), .XTAL_TICK_I(xtal_tick),
		.LP_OSC_TICK_I(lp_tick), .HV_PREC_OSC_EN_I(hv_en), .WAKE_TMR_LP_SRC_I(wt_lp),
		.TIMER_SRC_PLL_I(tmr_pll), .CORE_CLK_EN_O(core_clk), .CORE_PWR_EN_O(core_pwr),
		.PERIPH_GATE_EN_O(gate), .PLL_PWR_EN_O(pll_pwr), .XTAL_PWR_EN_O(xtal_pwr),
		.PREC_IN_EN_O(prec_en), .LIN_WAKE_DET_EN_O(lin_en), .WAKE_TMR_RUN_O(wt_run),
		.TIMER_RUN_O(tmr_run), .LP_OSC_TRIM_O(trim));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		check_count++;
		if ($isunknown(got) || got < lo || got > hi) begin
			mismatches++;
			$display("FAIL %s expected %0d..%0d seen %h", nm, lo, hi, got);
		end
	endtask : chk_rng

	task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
	endtask : wr_reg

	// one read strobe; rdata is settled when this returns
	task automatic rd_reg(input logic [31:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd   <= 1'b0;
		#1;
	endtask : rd_reg

	task automatic chk_rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(nm, exp, rdata);
	endtask : chk_rd

	task automatic key_wr(input logic [7:0] v);
		wr_reg(PMC_ADDR_PREKEY, PMC_PREKEY_VAL);
		wr_reg(PMC_ADDR_POWCTL, {24'h0, v});
		wr_reg(PMC_ADDR_POSTKEY, PMC_POSTKEY_VAL);
		// idle cycle after the keyed write before any further access
		@(posedge clk_sys);
		#1;
	endtask : key_wr

	// all five peripheral gates follow the single peripheral bit
	task automatic pins_chk(input logic [7:0] pc);
		chk("power pins", {24'h0, pc[6], pc[5], {5{pc[4]}}, pc[3]},
			{24'h0, xtal_pwr, pll_pwr, gate, core_pwr});
	endtask : pins_chk

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	task automatic t_reset();
		chk_rd("power_control", PMC_ADDR_POWCTL, 32'h79);
		chk_rd("lp_osc_trim", PMC_ADDR_TRIM, 32'h8);
		chk_rd("calibration_control", PMC_ADDR_CALCTL, 32'h0);
		wr_reg(PMC_ADDR_CALSTA, 32'hff);
		chk_rd("calibration_status", PMC_ADDR_CALSTA, 32'h0);
		chk_rd("reference_count", PMC_ADDR_REFCNT, 32'h0);
		chk_rd("lowpower_count", PMC_ADDR_LPCNT, 32'h0);
		chk_rd("unmapped", 32'hffff0500, 32'h0);
		pins_chk(8'h79);
		chk("lin wake", 32'h1, lin_en);
		end_test("reset");
	endtask : t_reset

	task automatic t_keys();
		wr_reg(PMC_ADDR_POWCTL, 32'h0);
		chk_rd("unkeyed write", PMC_ADDR_POWCTL, 32'h79);
		wr_reg(PMC_ADDR_PREKEY, PMC_PREKEY_VAL);
		wr_reg(PMC_ADDR_TRIM, 32'h8);
		wr_reg(PMC_ADDR_POWCTL, 32'h0);
		wr_reg(PMC_ADDR_POSTKEY, PMC_POSTKEY_VAL);
		chk_rd("broken key", PMC_ADDR_POWCTL, 32'h79);
		key_wr(8'h51);
		chk_rd("pll held on", PMC_ADDR_POWCTL, 32'h71);
		key_wr(8'h29);
		chk_rd("periph held on", PMC_ADDR_POWCTL, 32'h39);
		key_wr(8'h00);
		pins_chk(8'h00);
		chk("pll timer", 32'h0, tmr_run);
		chk("wake timer", 32'h0, wt_run);
		@(posedge clk_sys);
		tmr_pll <= 1'b0;
		wt_lp   <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("osc timer", 32'h1, tmr_run);
		chk("lp wake timer", 32'h1, wt_run);
		chk("lin wake", 32'h1, lin_en);
		@(posedge clk_sys);
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		@(posedge clk_sys);
		#1;
		pins_chk(8'h38);
		chk_rd("after wake", PMC_ADDR_POWCTL, 32'h38);
		key_wr(8'h41);
		pins_chk(8'h41);
		end_test("keys");
	endtask : t_keys

	task automatic t_prec();
		key_wr(8'hf9);
		chk("prec without hv", 32'h0, prec_en);
		@(posedge clk_sys);
		hv_en <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("prec with hv", 32'h1, prec_en);
		key_wr(8'h79);
		chk("prec bit clear", 32'h0, prec_en);
		end_test("precision input");
	endtask : t_prec

	task automatic t_div();
		int n;
		@(posedge clk_sys);
		pll_tick <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			key_wr(8'h78 | c[7:0]);
			n = 0;
			repeat (512) begin
				@(posedge clk_sys);
				#1;
				n += (core_clk === 1'b1);
			end
			chk_rng("core clock pulses", (512 >> c) - 1, (512 >> c) + 1, n);
		end
		@(posedge clk_sys);
		pll_tick <= 1'b0;
		end_test("divider");
	endtask : t_div

	task automatic t_trim();
		wr_reg(PMC_ADDR_TRIM, 32'hff);
		chk_rd("trim readback", PMC_ADDR_TRIM, 32'h0f);
		chk("trim pins", 32'hf, trim);
		end_test("trim");
	endtask : t_trim

	// polls status every cycle so the one-cycle finished state is not missed
	task automatic run_cal(input logic [7:0] ctl);
		logic [2:0] seen;
		seen = '0;
		wr_reg(PMC_ADDR_CALCTL, {24'h0, ctl});
		addr <= PMC_ADDR_CALSTA;
		rd   <= 1'b1;
		for (int i = 0; i < 3000 && !(seen[2] && rdata[3:0] === 4'h0); i++) begin
			@(posedge clk_sys);
			#1;
			seen |= {rdata[7:0] === 8'h0e, rdata[7:0] === 8'h0b, rdata[7:0] === 8'h07};
		end
		@(posedge clk_sys);
		rd <= 1'b0;
		chk("status walk", 32'h7, seen);
		chk_rd("status after run", PMC_ADDR_CALSTA, 32'h0);
		chk_rd("reference stop", PMC_ADDR_REFCNT, 32'h1ff);
	endtask : run_cal

	task automatic t_cal();
		// the PLL source selection sits outside this block and is taken as already moved
		key_wr(8'hf9);
		@(posedge clk_sys);
		prec_tick <= 1'b1;
		lp_tick   <= 1'b1;
		run_cal(8'h01);
		chk_rd("lowpower direct", PMC_ADDR_LPCNT, 32'h1ff);
		wr_reg(PMC_ADDR_CALCTL, 32'h04);
		chk_rd("lp clear", PMC_ADDR_LPCNT, 32'h0);
		chk_rd("ref kept", PMC_ADDR_REFCNT, 32'h1ff);
		wr_reg(PMC_ADDR_CALCTL, 32'h02);
		chk_rd("ref clear", PMC_ADDR_REFCNT, 32'h0);
		@(posedge clk_sys);
		prec_tick <= 1'b0;
		xtal_tick <= 1'b1;
		run_cal(8'h11);
		rd_reg(PMC_ADDR_LPCNT);
		chk_rng("lowpower quartered", 126, 129, rdata);
		wr_reg(PMC_ADDR_CALCTL, 32'h18);
		chk_rd("reset ref", PMC_ADDR_REFCNT, 32'h0);
		chk_rd("reset lp", PMC_ADDR_LPCNT, 32'h0);
		chk_rd("reset control", PMC_ADDR_CALCTL, 32'h10);
		@(posedge clk_sys);
		prec_tick <= 1'b1;
		xtal_tick <= 1'b0;
		wr_reg(PMC_ADDR_CALCTL, 32'h01);
		repeat (20) @(posedge clk_sys);
		wr_reg(PMC_ADDR_CALCTL, 32'h00);
		chk_rd("abort status", PMC_ADDR_CALSTA, 32'h0);
		chk_rd("abort control", PMC_ADDR_CALCTL, 32'h0);
		// an aborted run keeps its partial count
		rd_reg(PMC_ADDR_REFCNT);
		chk_rng("abort partial count", 1, 510, rdata);
		end_test("calibration");
	endtask : t_cal

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_keys();
		t_prec();
		t_div();
		t_trim();
		t_cal();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
